// >>> analog_front.sv
// Analog inputs and timer channel pin seen by the comparator block
`timescale 1ns/1ps
module analog_front
#(
	parameter logic [7:0] BANDGAP_LVL = 8'h40
)
(
	input wire logic mclk,
	input wire logic [7:0] pos_lvl,
	input wire logic [7:0] neg_lvl,
	input wire logic pin_lvl,
	input wire logic reference_source_select,
	input wire logic bandgap_buffer_enable,
	input wire logic comparator_power_enable,
	input wire logic first_timer_channel_zero_pin_disable,
	output logic analog_compare_raw,
	output logic first_timer_channel_zero_pin
);
	logic noise_q = 1'b0;
	always @(posedge mclk)
	begin
		noise_q <= ~noise_q;
	end
	always_comb
	begin
		if (!comparator_power_enable)
			analog_compare_raw = noise_q;
		else if (reference_source_select)
			analog_compare_raw = bandgap_buffer_enable ? (BANDGAP_LVL > neg_lvl) : noise_q;
		else
			analog_compare_raw = pos_lvl > neg_lvl;
	end
	assign first_timer_channel_zero_pin = first_timer_channel_zero_pin_disable ? noise_q : pin_lvl;
endmodule

// >>> comparator_mode_control.sv
// Voltage comparator control: reference select, routing, edge flags, low-power modes
`timescale 1ns/1ps
//
// Contract
// RL1 - Software enables bandgap buffer before selecting bandgap
// RL2 - Capture route feeds result to timer channel
// RL3 - Capture route takes channel pin away
// RL4 - Interrupt on rising, falling or either edge
// RL5 - Result can drive dedicated output pin
// RL6 - Comparator keeps running in wait mode
// RL7 - Event in wait raises waking interrupt
// RL8 - Software disables comparator in wait if unused
// RL9 - Light stop keeps comparing and detecting
// RL10 - Light stop still drives output pin
// RL11 - Light stop event sets flag, wakes
// RL12 - Reset leaving stop restores reset state
// RL13 - Deep stop powers down, wakes in reset; code keeps route_q and bg_buf_q through deep stop
// RL14 - Background debug does not freeze comparator
// RL15 - Edge field: 00/10 fall, 01 rise, 11 both
// RL16 - Flag set by event, cleared writing one
// RL17 - Result bit live, zero when disabled
// RL18 - Reference select: 0 pin, 1 bandgap
// RL19 - Synchronise analog result before edge detect
// RL20 - No edge detection while disabled
module comparator_mode_control
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic analog_compare_raw,
	input wire logic wait_mode,
	input wire logic light_stop_mode,
	input wire logic deep_stop_mode,
	input wire logic debug_halt,
	output logic comparator_power_enable,
	output logic reference_source_select,
	output logic bandgap_buffer_enable,
	output logic comparator_output_pin,
	output logic comparator_output_pin_oe,
	output logic first_timer_capture_in,
	input wire logic first_timer_channel_zero_pin,
	output logic first_timer_channel_zero_pin_disable,
	output logic compare_interrupt,
	output logic wake_request
);
	// ==========================================
	// Control state
	logic module_enable_q, module_enable_d;
	logic ref_sel_q, ref_sel_d;
	logic flag_q, flag_d;
	logic irq_en_q, irq_en_d;
	logic pin_en_q, pin_en_d;
	logic [1:0] edge_sel_q, edge_sel_d;
	logic route_q, route_d;
	logic bg_buf_q, bg_buf_d;
	logic sync1_q, sync1_d;
	logic sync2_q, sync2_d;
	logic prev_q, prev_d;
	logic [2:0] armed_q, armed_d;
	logic [7:0] rdata_q, rdata_d;
	logic event_hit;
	logic wr_ctl;
	logic live_result;
	logic [7:0] status_word;

	function automatic logic edge_match(input logic [1:0] sel, input logic rise,
		input logic fall);
		case (sel)
			comparator_mode_control_pkg::EDGE_RISE: edge_match = rise;
			comparator_mode_control_pkg::EDGE_BOTH: edge_match = rise | fall;
			comparator_mode_control_pkg::EDGE_FALL_A: edge_match = fall;
			comparator_mode_control_pkg::EDGE_FALL_B: edge_match = fall;
			default: edge_match = fall;
		endcase
	endfunction

	// ==========================================
	// Next values
	always_comb
	begin
		wr_ctl = reg_write && (reg_addr == comparator_mode_control_pkg::STATUS_CONTROL_OFS);
		// RL19 two-stage synchroniser
		sync1_d = analog_compare_raw;
		sync2_d = sync1_q;
		prev_d = sync2_q;
		// RL20 arm only once the pipe holds powered samples
		armed_d = {armed_q[1:0], module_enable_q} & {3{module_enable_q}};
		// RL17 live result gated
		live_result = module_enable_q & sync2_q;
		// RL4 RL15 RL20 edge select
		event_hit = module_enable_q && armed_q[2] &&
			edge_match(edge_sel_q, sync2_q & ~prev_q, ~sync2_q & prev_q);
		module_enable_d = module_enable_q;
		ref_sel_d = ref_sel_q;
		irq_en_d = irq_en_q;
		pin_en_d = pin_en_q;
		edge_sel_d = edge_sel_q;
		route_d = route_q;
		bg_buf_d = bg_buf_q;
		flag_d = flag_q;
		if (wr_ctl)
		begin
			module_enable_d = reg_wdata[comparator_mode_control_pkg::MODULE_ENABLE_BIT];
			// RL18 reference select
			ref_sel_d = reg_wdata[comparator_mode_control_pkg::REFERENCE_SOURCE_SELECT_BIT];
			irq_en_d = reg_wdata[comparator_mode_control_pkg::COMPARE_INTERRUPT_ENABLE_BIT];
			pin_en_d = reg_wdata[comparator_mode_control_pkg::OUTPUT_PIN_ENABLE_BIT];
			edge_sel_d = reg_wdata[comparator_mode_control_pkg::EVENT_EDGE_SELECT_LSB +: 2];
			// RL16 write one clears
			if (reg_wdata[comparator_mode_control_pkg::COMPARE_EVENT_FLAG_BIT])
			begin
				flag_d = 1'b0;
			end
		end
		// RL16 RL11 set wins over clear
		if (event_hit)
		begin
			flag_d = 1'b1;
		end
		if (reg_write && reg_addr == comparator_mode_control_pkg::SYSTEM_OPTIONS_TWO_OFS)
		begin
			route_d = reg_wdata[comparator_mode_control_pkg::CAPTURE_ROUTE_BIT];
		end
		if (reg_write && reg_addr == comparator_mode_control_pkg::POWER_MGMT_CONTROL_ONE_OFS)
		begin
			bg_buf_d = reg_wdata[comparator_mode_control_pkg::BANDGAP_BUFFER_ENABLE_BIT];
		end
		status_word = {module_enable_q, ref_sel_q, flag_q, irq_en_q, live_result, pin_en_q,
			edge_sel_q};
		rdata_d = 8'h00;
		if (reg_read)
		begin
			case (reg_addr)
				comparator_mode_control_pkg::STATUS_CONTROL_OFS: rdata_d = status_word;
				comparator_mode_control_pkg::SYSTEM_OPTIONS_TWO_OFS: rdata_d = {7'h00, route_q};
				comparator_mode_control_pkg::POWER_MGMT_CONTROL_ONE_OFS:
					rdata_d = {7'h00, bg_buf_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// ==========================================
	// Registers
	// RL12 RL13 deep stop returns reset state except route_q and bg_buf_q, which keep their values
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			module_enable_q <= 1'b0;
			ref_sel_q <= 1'b0;
			flag_q <= 1'b0;
			irq_en_q <= 1'b0;
			pin_en_q <= 1'b0;
			edge_sel_q <= comparator_mode_control_pkg::EVENT_EDGE_SELECT_RST;
			route_q <= 1'b0;
			bg_buf_q <= 1'b0;
			armed_q <= 3'h0;
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
			rdata_q <= 8'h00;
		end
		else if (deep_stop_mode)
		begin
			module_enable_q <= 1'b0;
			ref_sel_q <= 1'b0;
			flag_q <= 1'b0;
			irq_en_q <= 1'b0;
			pin_en_q <= 1'b0;
			edge_sel_q <= comparator_mode_control_pkg::EVENT_EDGE_SELECT_RST;
			armed_q <= 3'h0;
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
			rdata_q <= 8'h00;
		end
		else
		begin
			// RL6 RL9 RL14 no freeze in low power or debug
			module_enable_q <= module_enable_d;
			ref_sel_q <= ref_sel_d;
			flag_q <= flag_d;
			irq_en_q <= irq_en_d;
			pin_en_q <= pin_en_d;
			edge_sel_q <= edge_sel_d;
			route_q <= route_d;
			bg_buf_q <= bg_buf_d;
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			prev_q <= prev_d;
			armed_q <= armed_d;
			rdata_q <= rdata_d;
		end
	end

	// ==========================================
	// Outputs
	assign reg_rdata = rdata_q;
	assign comparator_power_enable = module_enable_q & ~deep_stop_mode;
	assign reference_source_select = ref_sel_q;
	// RL1 buffer bit held for software
	assign bandgap_buffer_enable = bg_buf_q;
	// RL5 RL10 output pin drive
	assign comparator_output_pin = live_result;
	assign comparator_output_pin_oe = pin_en_q & module_enable_q;
	// RL2 capture routing
	assign first_timer_capture_in = route_q ? live_result : first_timer_channel_zero_pin;
	// RL3 channel pin taken away
	assign first_timer_channel_zero_pin_disable = route_q;
	// RL7 RL16 interrupt
	assign compare_interrupt = flag_q & irq_en_q;
	// RL7 RL11 wake request
	assign wake_request = compare_interrupt & (wait_mode | light_stop_mode);

	// ==========================================
	// Checks
	AST_FLAG_SET: assert property (@(posedge mclk) disable iff (rst || deep_stop_mode)
		event_hit |=> flag_q) else $error("flag not set after event"); // RL16
	AST_CLEAR_ONE: assert property (@(posedge mclk) disable iff (rst || deep_stop_mode)
		(wr_ctl && reg_wdata[5] && !event_hit) |=> !flag_q) else $error("flag not cleared"); // RL16
	AST_NO_SPURIOUS: assert property (@(posedge mclk) disable iff (rst || deep_stop_mode)
		(!flag_q && !event_hit) |=> !flag_q) else $error("flag set without event"); // RL16
	AST_RISE_ONLY: assert property (@(posedge mclk) disable iff (rst)
		(event_hit && edge_sel_q == 2'h1) |-> (sync2_q && !prev_q)) else $error("bad rise"); // RL15
	AST_FALL_SEL: assert property (@(posedge mclk) disable iff (rst)
		(event_hit && !edge_sel_q[0]) |-> (!sync2_q && prev_q)) else $error("bad fall"); // RL15
	AST_DISABLED: assert property (@(posedge mclk) disable iff (rst)
		!module_enable_q |-> (!event_hit && !live_result)) else $error("active when off"); // RL20
	AST_RESULT_READ: assert property (@(posedge mclk) disable iff (rst || deep_stop_mode)
		(reg_read && reg_addr == 8'h00) |=> reg_rdata[3] == $past(live_result))
		else $error("result read wrong"); // RL17
	AST_IRQ: assert property (@(posedge mclk) disable iff (rst)
		compare_interrupt == (flag_q && irq_en_q)) else $error("irq mismatch"); // RL16
	AST_ROUTE: assert property (@(posedge mclk) disable iff (rst)
		route_q |-> (first_timer_capture_in == live_result && first_timer_channel_zero_pin_disable))
		else $error("route wrong"); // RL2
	AST_DEEP: assert property (@(posedge mclk) disable iff (rst)
		deep_stop_mode |=> (!module_enable_q && !flag_q)) else $error("deep stop state kept"); // RL13
	AST_WAKE: assert property (@(posedge mclk) disable iff (rst)
		(compare_interrupt && light_stop_mode) |-> wake_request) else $error("no wake"); // RL11

	// ==========================================
	// Further checks
	// RL20 no event before arming
	AST_ARM_GATE: assert property (@(posedge mclk) disable iff (rst) // RL20
		!armed_q[2] |-> !event_hit)
		else $error("event before arming");
	// RL7 wake in wait
	AST_WAIT_WAKE: assert property (@(posedge mclk) disable iff (rst) // RL7
		(compare_interrupt && wait_mode) |-> wake_request)
		else $error("no wake in wait");
	// RL7 no wake without interrupt
	AST_NO_WAKE: assert property (@(posedge mclk) disable iff (rst) // RL7
		!compare_interrupt |-> !wake_request)
		else $error("wake without interrupt");
	// RL10 pin driven in light stop
	AST_LIGHT_PIN: assert property (@(posedge mclk) disable iff (rst) // RL10
		(light_stop_mode && pin_en_q && module_enable_q) |->
		(comparator_output_pin_oe && comparator_output_pin == sync2_q))
		else $error("pin not driven in light stop");
	// RL3 pin free when not routed
	AST_PIN_FREE: assert property (@(posedge mclk) disable iff (rst) // RL3
		!route_q |-> (first_timer_capture_in == first_timer_channel_zero_pin &&
		!first_timer_channel_zero_pin_disable))
		else $error("channel pin not free");
	// RL13 powered down in deep stop
	AST_POWER_DOWN: assert property (@(posedge mclk) disable iff (rst) // RL13
		deep_stop_mode |-> !comparator_power_enable)
		else $error("powered in deep stop");
	// RL19 second stage follows first
	AST_SYNC_CHAIN: assert property (@(posedge mclk) disable iff (rst || deep_stop_mode) // RL19
		!$past(deep_stop_mode) |-> sync2_q == $past(sync1_q))
		else $error("sync chain broken");
	// RL19 edge history follows second stage
	AST_PREV_TRACK: assert property (@(posedge mclk) disable iff (rst || deep_stop_mode) // RL19
		!$past(deep_stop_mode) |-> prev_q == $past(sync2_q))
		else $error("edge history broken");
	// RL14 sampling goes on in debug halt
	AST_DEBUG_RUN: assert property (@(posedge mclk) disable iff (rst || deep_stop_mode) // RL14
		(debug_halt && module_enable_q) |=> sync1_q == $past(analog_compare_raw))
		else $error("frozen in debug halt");
endmodule

// >>> comparator_mode_control_pkg.sv
// Constants for the voltage comparator control block
package comparator_mode_control_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] STATUS_CONTROL_OFS = 8'h00;
	localparam logic [7:0] SYSTEM_OPTIONS_TWO_OFS = 8'h01;
	localparam logic [7:0] POWER_MGMT_CONTROL_ONE_OFS = 8'h02;
	// ==========================================
	// Status and control field positions
	localparam int MODULE_ENABLE_BIT = 7;
	localparam int REFERENCE_SOURCE_SELECT_BIT = 6;
	localparam int COMPARE_EVENT_FLAG_BIT = 5;
	localparam int COMPARE_INTERRUPT_ENABLE_BIT = 4;
	localparam int LIVE_COMPARE_RESULT_BIT = 3;
	localparam int OUTPUT_PIN_ENABLE_BIT = 2;
	localparam int EVENT_EDGE_SELECT_LSB = 0;
	// Option bit positions
	localparam int CAPTURE_ROUTE_BIT = 0;
	localparam int BANDGAP_BUFFER_ENABLE_BIT = 0;
	// ==========================================
	// Reset values
	localparam logic [7:0] STATUS_CONTROL_RST = 8'h00;
	localparam logic [1:0] EVENT_EDGE_SELECT_RST = 2'h0;
	// Edge select encodings
	localparam logic [1:0] EDGE_FALL_A = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL_B = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// >>> tb.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb;
	logic mclk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, pin_lvl = 1'b0;
	logic wait_mode = 1'b0, light_stop_mode = 1'b0, deep_stop_mode = 1'b0, debug_halt = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, pos_lvl = 8'h10, neg_lvl = 8'h80;
	logic raw, tpin, pwr, rsel, bgb, opin, opin_oe, cap, pdis, irq, wake, hit;
	logic [7:0] base;
	int n_mismatch = 0, checks = 0, cyc = 0;
	// ==========================================
	// Design and partner
	comparator_mode_control uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .analog_compare_raw(raw), .wait_mode(wait_mode),
		.light_stop_mode(light_stop_mode), .deep_stop_mode(deep_stop_mode),
		.debug_halt(debug_halt), .comparator_power_enable(pwr), .reference_source_select(rsel),
		.bandgap_buffer_enable(bgb), .comparator_output_pin(opin),
		.comparator_output_pin_oe(opin_oe), .first_timer_capture_in(cap),
		.first_timer_channel_zero_pin(tpin), .first_timer_channel_zero_pin_disable(pdis),
		.compare_interrupt(irq), .wake_request(wake));
	analog_front partner (.mclk(mclk), .pos_lvl(pos_lvl), .neg_lvl(neg_lvl), .pin_lvl(pin_lvl),
		.reference_source_select(rsel), .bandgap_buffer_enable(bgb),
		.comparator_power_enable(pwr), .first_timer_channel_zero_pin_disable(pdis),
		.analog_compare_raw(raw), .first_timer_channel_zero_pin(tpin));
	always #12.5 mclk = ~mclk;
	// ==========================================
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		@(negedge mclk);
		chk(reg_rdata, e);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic summarize;
		if (n_mismatch == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	// ==========================================
	// Tests
	initial
	begin
		settle(16);
		rst <= 1'b0;
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
		wr(8'h03, 8'hff);
		rd(8'h03, 8'h00);
		for (int m = 0; m < 4; m++)
		begin
			base = 8'h94 | 8'(m);
			wait_mode <= (m == 1);
			light_stop_mode <= (m == 2);
			debug_halt <= (m == 3);
			wr(8'h00, base);
			settle(4);
			pos_lvl <= 8'hf0;
			settle(6);
			hit = (m == 1 || m == 3);
			rd(8'h00, base | 8'h08 | (hit ? 8'h20 : 8'h00));
			chk(8'({irq, wake, opin, opin_oe}), {4'h0, hit, hit & (m < 3), 2'h3});
			wr(8'h00, base | 8'h20);
			pos_lvl <= 8'h10;
			settle(6);
			hit = (m != 1);
			rd(8'h00, base | (hit ? 8'h20 : 8'h00));
			chk(8'(wake), 8'(hit & (m == 1 || m == 2)));
			wr(8'h00, base | 8'h20);
			rd(8'h00, base);
		end
		wr(8'h00, 8'h00);
		pos_lvl <= 8'hf0;
		settle(6);
		rd(8'h00, 8'h00);
		wr(8'h00, 8'h81);
		settle(6);
		rd(8'h00, 8'h89);
		wr(8'h01, 8'h01);
		settle(2);
		chk(8'({cap, pdis}), 8'h03);
		wr(8'h01, 8'h00);
		pin_lvl <= 1'b1;
		settle(2);
		chk(8'({cap, pdis}), 8'h02);
		wr(8'h02, 8'h01);
		wr(8'h00, 8'hc1);
		settle(6);
		chk(8'({rsel, bgb}), 8'h03);
		rd(8'h00, 8'hc1);
		deep_stop_mode <= 1'b1;
		settle(3);
		chk(8'(pwr), 8'h00);
		deep_stop_mode <= 1'b0;
		rd(8'h00, 8'h00);
		wr(8'h00, 8'h94);
		light_stop_mode <= 1'b1;
		rst <= 1'b1;
		settle(2);
		rst <= 1'b0;
		rd(8'h00, 8'h00);
		summarize();
	end
endmodule
